// ===== system_protection_monitors.sv
// Purpose: bus, halt, spurious interrupt and watchdog monitors
// Assumes: core signals synchronous to clk
// Notes: cause register survives the reset that this block requests
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module system_protection_monitors #(
    parameter int wd_period = prot_pkg::wd_period_default
) (
    input wire logic clk,
    input wire logic rstn,
    input wire prot_pkg::core_in_t core_in,
    output prot_pkg::core_out_t core_out,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import prot_pkg::*;

    localparam logic [31:0] wd_limit = 32'(wd_period);

    typedef enum logic [1:0] {
        svc_idle,
        svc_armed
    } svc_state_t;

    typedef struct packed {
        logic [4:0] ctrl;
        logic halt_cause;
        logic wdog_cause;
        logic [3:0] status;
        logic [3:0] mask;
        svc_state_t svc;
        logic [31:0] wd_count;
        logic [2:0] rst_hold;
        logic bus_error;
        logic system_reset;
        logic irq;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic awready;
        logic wready;
        logic arready;
    } top_state_t;

    top_state_t st_ff, nxt_st;
    logic bm_timeout;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == ctrl_off) || (a == cause_off) || (a == service_off)
            || (a == status_off) || (a == mask_off);
    endfunction

    bus_monitor u_bus_monitor (
        .clk(clk),
        .rstn(rstn),
        .enable(st_ff.ctrl[bme_bit]),
        .period_sel(st_ff.ctrl[bmt_lsb+1:bmt_lsb]),
        .cycle_start(core_in.cycle_start),
        .cpu_master(core_in.cpu_master),
        .byte_split(core_in.byte_split),
        .data_size_ack(core_in.data_size_ack),
        .timeout(bm_timeout)
    );

    always_comb begin
        logic [3:0] ev;
        logic spur;
        logic halt_rst;
        logic wd_expire;
        logic serviced;
        logic do_write;
        logic [3:0] clr;
        ev = 4'h0;
        clr = 4'h0;
        nxt_st = st_ff;
        serviced = 1'b0;
        do_write = 1'b0;
        spur = 1'b0;
        halt_rst = 1'b0;
        wd_expire = 1'b0;

        // spurious monitor has no enable on purpose
        spur = core_in.iack_active && !core_in.arbitration_seen;
        nxt_st.bus_error = bm_timeout || spur;

        halt_rst = core_in.halt && st_ff.ctrl[hme_bit];

        // write channel: take address and data in either order
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
            nxt_st.awready = 1'b0;
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_got = 1'b1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
            nxt_st.wready = 1'b0;
        end
        if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
            do_write = 1'b1;
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = mapped(st_ff.aw_addr) ? resp_okay : resp_slverr;
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
            nxt_st.awready = 1'b1;
            nxt_st.wready = 1'b1;
        end

        if (do_write && st_ff.w_strb[0]) begin
            case (st_ff.aw_addr)
                ctrl_off: nxt_st.ctrl = st_ff.w_data[4:0];
                cause_off: begin
                    nxt_st.halt_cause = st_ff.halt_cause & ~st_ff.w_data[0];
                    nxt_st.wdog_cause = st_ff.wdog_cause & ~st_ff.w_data[1];
                end
                service_off: begin
                    // any byte other than key_first or key_second breaks the pair; key_first re-arms
                    if (st_ff.w_data[7:0] == key_first) begin
                        nxt_st.svc = svc_armed;
                    end else if (st_ff.svc == svc_armed
                        && st_ff.w_data[7:0] == key_second) begin
                        serviced = 1'b1;
                        nxt_st.svc = svc_idle;
                    end else begin
                        nxt_st.svc = svc_idle;
                    end
                end
                status_off: clr = st_ff.w_data[3:0];
                mask_off: nxt_st.mask = st_ff.w_data[3:0];
                default: ;
            endcase
        end

        // watchdog
        if (!st_ff.ctrl[swe_bit] || serviced) begin
            nxt_st.wd_count = 32'h0;
        end else if (st_ff.wd_count + 32'h1 >= wd_limit) begin
            wd_expire = 1'b1;
            nxt_st.wd_count = 32'h0;
        end else begin
            nxt_st.wd_count = st_ff.wd_count + 32'h1;
        end

        // reset request held a few cycles so the reset tree sees it
        if (halt_rst || wd_expire) begin
            nxt_st.rst_hold = 3'h7;
            nxt_st.halt_cause = halt_rst;
            nxt_st.wdog_cause = wd_expire;
        end else if (st_ff.rst_hold != 3'h0) begin
            nxt_st.rst_hold = st_ff.rst_hold - 3'h1;
        end
        nxt_st.system_reset = halt_rst || wd_expire || (st_ff.rst_hold > 3'h1);

        ev[ev_bus] = bm_timeout;
        ev[ev_spur] = spur;
        ev[ev_halt] = halt_rst;
        ev[ev_wdog] = wd_expire;
        // set beats clear
        nxt_st.status = (st_ff.status & ~clr) | ev;
        nxt_st.irq = |(nxt_st.status & nxt_st.mask);

        // read channel
        if (s_axi_arvalid && st_ff.arready) begin
            nxt_st.arready = 1'b0;
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = mapped(s_axi_araddr) ? resp_okay : resp_slverr;
            case (s_axi_araddr)
                ctrl_off: nxt_st.rdata = {27'h0, st_ff.ctrl};
                cause_off: nxt_st.rdata = {30'h0, st_ff.wdog_cause, st_ff.halt_cause};
                service_off: nxt_st.rdata = {31'h0, st_ff.svc == svc_armed};
                status_off: nxt_st.rdata = {28'h0, st_ff.status};
                mask_off: nxt_st.rdata = {28'h0, st_ff.mask};
                default: nxt_st.rdata = 32'h0;
            endcase
        end
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
            nxt_st.arready = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_ff <= '0;
            st_ff.ctrl <= ctrl_rst;
            st_ff.svc <= svc_idle;
            st_ff.awready <= 1'b1;
            st_ff.wready <= 1'b1;
            st_ff.arready <= 1'b1;
            // cause flags kept across reset so software can read them
            st_ff.halt_cause <= st_ff.halt_cause;
            st_ff.wdog_cause <= st_ff.wdog_cause;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign core_out.bus_error_line = st_ff.bus_error;
    assign core_out.system_reset = st_ff.system_reset;
    assign irq = st_ff.irq;
    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready = st_ff.wready;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rresp = st_ff.rresp;
    assign s_axi_rdata = st_ff.rdata;
endmodule // system_protection_monitors

// ===== prot_pkg.sv
// Purpose: shared constants and carriers for the protection monitors
// Assumes: 50 MHz system clock, AXI4-Lite register access
// Notes: offsets are byte addresses
package prot_pkg;
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] cause_off = 8'h04;
    localparam logic [7:0] service_off = 8'h08;
    localparam logic [7:0] status_off = 8'h0c;
    localparam logic [7:0] mask_off = 8'h10;
    localparam int bme_bit = 0;
    localparam int hme_bit = 1;
    localparam int swe_bit = 2;
    localparam int bmt_lsb = 3;
    localparam logic [4:0] ctrl_rst = 5'h00;
    localparam logic [7:0] key_first = 8'h55;
    localparam logic [7:0] key_second = 8'haa;
    localparam logic [6:0] bm_count_64 = 7'h40;
    localparam logic [6:0] bm_count_32 = 7'h20;
    localparam logic [6:0] bm_count_16 = 7'h10;
    localparam logic [6:0] bm_count_8 = 7'h08;
    localparam int wd_period_default = 100000;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    // status bits: 0 bus timeout, 1 spurious, 2 halt, 3 watchdog
    localparam int ev_bus = 0;
    localparam int ev_spur = 1;
    localparam int ev_halt = 2;
    localparam int ev_wdog = 3;

    typedef struct packed {
        logic cycle_start;
        logic cpu_master;
        logic byte_split;
        logic data_size_ack;
        logic halt;
        logic iack_active;
        logic arbitration_seen;
    } core_in_t;

    typedef struct packed {
        logic bus_error_line;
        logic system_reset;
    } core_out_t;
endpackage

// ===== bus_monitor.sv
// Purpose: bus cycle timeout counter
// Assumes: cycle_start pulses once per core access
// Notes: error is a one-cycle pulse
`timescale 1ns/1ps
module bus_monitor (
    input wire logic clk,
    input wire logic rstn,
    input wire logic enable,
    input wire logic [1:0] period_sel,
    input wire logic cycle_start,
    input wire logic cpu_master,
    input wire logic byte_split,
    input wire logic data_size_ack,
    output logic timeout
);
    import prot_pkg::*;
    typedef struct packed {
        logic busy;
        logic second_pending;
        logic [6:0] count;
        logic timeout;
    } bm_state_t;
    bm_state_t st_ff, nxt_st;

    function automatic logic [6:0] limit(input logic [1:0] sel);
        case (sel)
            2'h0: limit = bm_count_64;
            2'h1: limit = bm_count_32;
            2'h2: limit = bm_count_16;
            default: limit = bm_count_8;
        endcase
    endfunction

    always_comb begin
        nxt_st = st_ff;
        nxt_st.timeout = 1'b0;
        if (!enable) begin
            nxt_st.busy = 1'b0;
            nxt_st.second_pending = 1'b0;
            nxt_st.count = 7'h00;
        end else if (!st_ff.busy) begin
            if (cycle_start && cpu_master) begin
                nxt_st.busy = 1'b1;
                nxt_st.second_pending = byte_split;
                nxt_st.count = 7'h00;
            end
        end else if (data_size_ack) begin
            // split word keeps counting across both bytes
            if (st_ff.second_pending) begin
                nxt_st.second_pending = 1'b0;
                nxt_st.count = st_ff.count + 7'h01;
            end else begin
                nxt_st.busy = 1'b0;
            end
        end else if (st_ff.count + 7'h01 >= limit(period_sel)) begin
            nxt_st.busy = 1'b0;
            nxt_st.timeout = 1'b1;
        end else begin
            nxt_st.count = st_ff.count + 7'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign timeout = st_ff.timeout;
endmodule // bus_monitor

// ===== prot_assertions.sv
// Purpose: port-level checker for the protection monitors
// Assumes: one clock, synchronous active-low reset
// Notes: bound onto the top module below
`timescale 1ns/1ps
module prot_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire prot_pkg::core_in_t core_in,
    input wire prot_pkg::core_out_t core_out,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import prot_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic spur;
    assign spur = core_in.iack_active && !core_in.arbitration_seen;
    AST_SPURIOUS: assert property (spur |=> core_out.bus_error_line)
        else $error("no bus error after unarbitrated acknowledge");
    AST_SPUR_RUN: assert property (spur ##1 spur |-> core_out.bus_error_line [*2])
        else $error("bus error dropped during spurious acknowledge");
    AST_RESET_LEN: assert property ($rose(core_out.system_reset)
        |-> core_out.system_reset [*7] ##1 !core_out.system_reset)
        else $error("system reset not seven cycles long");
    AST_ACK_QUIET: assert property (core_in.cycle_start && core_in.cpu_master &&
        !core_in.byte_split ##1 core_in.data_size_ack |=> !core_out.bus_error_line [*4])
        else $error("bus error after acknowledged cycle");
    AST_EXT_QUIET: assert property (core_in.cycle_start && !core_in.cpu_master
        |=> !core_out.bus_error_line [*8])
        else $error("bus error on another master's cycle");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
        else $error("write response not retired");
    AST_AR_ANSWER: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered next cycle");
    AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read response not retired");
endmodule // prot_checker

bind system_protection_monitors prot_checker u_chk (.clk(clk), .rstn(rstn), .core_in(core_in),
    .core_out(core_out), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ===== core_model.sv
// Purpose: behavioural processor core on the monitored side
// Assumes: caller runs one task at a time
// Notes: split accesses need dly of 2 or more
`timescale 1ns/1ps
module core_model (
    input wire logic clk,
    output prot_pkg::core_in_t core_in
);
    import prot_pkg::*;
    initial core_in = '0;
    // dly 0 leaves the cycle unanswered
    task automatic access(input logic cpu, input logic split, input int dly);
        @(posedge clk);
        core_in.cycle_start <= 1'b1;
        core_in.cpu_master <= cpu;
        core_in.byte_split <= split;
        @(posedge clk);
        core_in.cycle_start <= 1'b0;
        if (dly > 0) begin
            repeat (split ? 2 : 1) begin
                repeat (dly - 1) @(posedge clk);
                core_in.data_size_ack <= 1'b1;
                @(posedge clk);
                core_in.data_size_ack <= 1'b0;
            end
        end
    endtask
    task automatic halt_pulse;
        @(posedge clk);
        core_in.halt <= 1'b1;
        @(posedge clk);
        core_in.halt <= 1'b0;
    endtask
    task automatic iack(input logic arb);
        @(posedge clk);
        core_in.iack_active <= 1'b1;
        core_in.arbitration_seen <= arb;
        repeat (3) @(posedge clk);
        core_in.iack_active <= 1'b0;
        core_in.arbitration_seen <= 1'b0;
    endtask
endmodule // core_model

// ===== tb_top.sv
// Purpose: self-checking bench for the protection monitors
// Assumes: short watchdog period so the run stays brief
// Notes: errors and resets are counted per cycle high
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) err_rep(32'(a), 32'(b)); end
module tb_top;
    import prot_pkg::*;
    localparam int wdp = 50;
    logic clk, rstn, irq;
    core_in_t core_in;
    core_out_t core_out;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, wresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    int fail_count = 0, cmp_count = 0, cyc = 0, err_cnt = 0, rst_cnt = 0, e0;
    system_protection_monitors #(.wd_period(wdp)) u_dut (.clk(clk), .rstn(rstn),
        .core_in(core_in), .core_out(core_out), .irq(irq), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    core_model u_core (.clk(clk), .core_in(core_in));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (core_out.bus_error_line === 1'b1) err_cnt <= err_cnt + 1;
        if (core_out.system_reset === 1'b1) rst_cnt <= rst_cnt + 1;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic err_rep(input logic [31:0] g, input logic [31:0] e);
        fail_count++;
        $display("wrong value at %0t got %h expected %h", $time, g, e);
    endtask
    task automatic close_out;
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // readiness sampled at the falling edge, so no race with the registered outputs
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ah, wh, bh;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        bh = 1'b0;
        while (!bh) begin
            @(negedge clk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            bh = bvalid && bready;
            wresp = bresp;
            @(posedge clk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ah, rh;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        rh = 1'b0;
        while (!rh) begin
            @(negedge clk);
            ah = arvalid && arready;
            rh = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ah) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        `CHK(d, e)
        `CHK(r, er)
    endtask
    task automatic quiet(input int n);
        e0 = err_cnt;
        repeat (n) @(negedge clk);
        `CHK(err_cnt - e0, 0)
    endtask
    task automatic t_regs;
        wr(cause_off, 32'h3);
        chk_rd(ctrl_off, 32'h0, resp_okay);
        chk_rd(cause_off, 32'h0, resp_okay);
        chk_rd(mask_off, 32'h0, resp_okay);
        // low byte strobe off: the write must be dropped
        wstrb <= 4'he;
        wr(mask_off, 32'hf);
        wstrb <= 4'hf;
        chk_rd(mask_off, 32'h0, resp_okay);
        wr(ctrl_off, 32'h1f);
        `CHK(wresp, resp_okay)
        chk_rd(ctrl_off, 32'h1f, resp_okay);
        wr(8'h40, 32'h0);
        `CHK(wresp, resp_slverr)
        chk_rd(8'h40, 32'h0, resp_slverr);
    endtask
    task automatic t_bus;
        int n, e;
        for (int s = 0; s < 4; s++) begin
            wr(ctrl_off, 32'(s << bmt_lsb) | 32'h1);
            u_core.access(1'b1, 1'b0, 0);
            e = 64 >> s;
            n = 0;
            while (core_out.bus_error_line !== 1'b1 && n < 100) begin
                @(negedge clk);
                n++;
            end
            `CHK((n >= e - 1) && (n <= e + 2), 1'b1)
        end
        @(negedge clk);
        `CHK(irq, 1'b0)
        wr(mask_off, 32'h1);
        @(negedge clk);
        `CHK(irq, 1'b1)
        wr(status_off, 32'hf);
        @(negedge clk);
        `CHK(irq, 1'b0)
        wr(ctrl_off, 32'h19);
        wr(ctrl_off, 32'h18);
        u_core.access(1'b1, 1'b0, 0);
        quiet(30);
    endtask
    task automatic t_ack;
        wr(ctrl_off, 32'h19);
        u_core.access(1'b1, 1'b0, 1);
        quiet(12);
        u_core.access(1'b1, 1'b0, 5);
        quiet(12);
        u_core.access(1'b0, 1'b0, 0);
        quiet(30);
        wr(ctrl_off, 32'h11);
        e0 = err_cnt;
        // second byte lands past the period only if the count kept running
        u_core.access(1'b1, 1'b1, 10);
        repeat (3) @(negedge clk);
        `CHK(err_cnt > e0, 1'b1)
    endtask
    task automatic t_halt;
        wr(ctrl_off, 32'h0);
        e0 = rst_cnt;
        u_core.halt_pulse();
        repeat (12) @(negedge clk);
        `CHK(rst_cnt - e0, 0)
        wr(ctrl_off, 32'h2);
        u_core.halt_pulse();
        repeat (12) @(negedge clk);
        `CHK(rst_cnt - e0, 7)
        chk_rd(cause_off, 32'h1, resp_okay);
        // bus timeout left over from the split test, plus the halt reset
        chk_rd(status_off, 32'h5, resp_okay);
        wr(cause_off, 32'h3);
    endtask
    task automatic t_spur;
        wr(ctrl_off, 32'h0);
        e0 = err_cnt;
        u_core.iack(1'b0);
        repeat (3) @(negedge clk);
        `CHK(err_cnt - e0, 3)
        u_core.iack(1'b1);
        quiet(6);
    endtask
    task automatic t_wdog;
        wr(ctrl_off, 32'h4);
        e0 = rst_cnt;
        repeat (3) begin
            repeat (15) @(posedge clk);
            wr(service_off, 32'(key_first));
            wr(service_off, 32'(key_second));
        end
        `CHK(rst_cnt - e0, 0)
        wr(service_off, 32'(key_first));
        chk_rd(service_off, 32'h1, resp_okay);
        wr(service_off, 32'h12);
        wr(service_off, 32'(key_second));
        repeat (60) @(negedge clk);
        `CHK(rst_cnt > e0, 1'b1)
        chk_rd(cause_off, 32'h2, resp_okay);
        wr(ctrl_off, 32'h0);
        e0 = rst_cnt;
        repeat (80) @(negedge clk);
        `CHK(rst_cnt - e0, 0)
    endtask
    initial begin
        rstn = 1'b0;
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hf;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_bus();
        t_ack();
        t_halt();
        t_spur();
        t_wdog();
        close_out();
    end
endmodule // tb_top
